/* design/cmc_control.sv */
// core memory cycle control sequencer
//
// Summary of operation
// - arbitrate pending requests; grant only the priority winner
// - with grant, in the same clock, pulse initiate and load the word address
// - read phase clears the word; ones are captured in data register
// - captured word goes to requester and to the parity check
// - an even count of ones raises the parity error signal
// - a read cycle gives the requester a data ready strobe
// - restore drives bit lines only where data register holds one
// - a release signal marks the end of every cycle
// - write clear phase discards the sensed old word
// - write data gets generated parity and loads the data register
// - write phase sets cores only where data register holds one
// - every cycle is a clear phase followed by a write phase
// - a word is driven only with word and bit drives together
// - drive polarity reads toward zero, writes toward one
// - words are 24 data bits plus odd parity in bit 24
// - priority: channel 1, 2, 3, then arithmetic unit last
// - requests during a cycle wait until the cycle completes
// - a complete memory cycle lasts 1.6 microseconds
`timescale 1ns/10ps
`default_nettype none
`include "cmc_params.svh"
module cmc_control #(
  parameter int NCH = `CMC_CHANNELS,
  parameter int DW = `CMC_DATA_W,
  parameter int AW = `CMC_ADDR_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // user devices, index 0 channel 1 ... index 3 arithmetic unit
  input wire logic [NCH-1:0] usr_req,
  input wire logic [NCH-1:0] usr_write,
  input wire logic [NCH-1:0][AW-1:0] usr_addr,
  input wire logic [NCH-1:0][DW-1:0] usr_wdata,
  output logic [NCH-1:0] usr_grant,
  output logic [NCH-1:0] usr_ready,
  output logic [NCH-1:0] usr_release,
  output logic [DW-1:0] usr_rdata,
  output logic parity_err,
  // core module
  output logic core_init,
  output logic [AW-1:0] core_addr,
  output logic word_drive,
  output logic [DW:0] bit_drive,
  output logic drive_write,
  input wire logic [DW:0] sense_data
);
  // ********************************
  // timing
  // ********************************
  // 32 clocks per cycle
  localparam int CYC = `CMC_CYCLE_NS / `CMC_CLK_NS;
  localparam int CLR_CYC = `CMC_CLEAR_NS / `CMC_CLK_NS;
  // init and release take one cycle each
  localparam int WR_CYC = CYC - 2 - CLR_CYC;
  localparam int CW = 6;
  localparam logic [CW-1:0] CLR_LAST = CW'(CLR_CYC - 1);
  localparam logic [CW-1:0] WR_LAST = CW'(WR_CYC - 1);

  // ********************************
  // state
  // ********************************
  typedef struct packed {
    cmc_pkg::cmc_state_t st;
    logic [CW-1:0] cnt;
    logic [$clog2(NCH)-1:0] sel;
    logic wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW:0] dreg;
    logic [NCH-1:0] grant;
    logic [NCH-1:0] ready;
    logic [NCH-1:0] rel;
    logic [DW-1:0] rdata;
    logic perr;
    logic init;
  } cmc_ctl_t;

  cmc_ctl_t s_q;
  cmc_ctl_t s_d;
  logic [NCH-1:0] arb_gnt;
  logic [$clog2(NCH)-1:0] arb_idx;
  logic arb_any;
  logic arb_open;

  cmc_arbiter #(.N(NCH)) u_arb (
    .req(usr_req),
    .gnt(arb_gnt),
    .idx(arb_idx),
    .any(arb_any)
  );

  assign arb_open = (s_q.st == cmc_pkg::ST_IDLE) ||
                    (s_q.st == cmc_pkg::ST_REL);

  // ********************************
  // sequencer
  // ********************************
  always_comb begin
    s_d = s_q;
    s_d.init = 1'b0;
    s_d.ready = '0;
    s_d.perr = 1'b0;
    s_d.rel = '0;
    unique case (s_q.st)
      cmc_pkg::ST_IDLE, cmc_pkg::ST_REL: begin
        if (arb_any) begin
          s_d.grant = arb_gnt;
          s_d.sel = arb_idx;
          s_d.wr = usr_write[arb_idx];
          s_d.addr = usr_addr[arb_idx];
          s_d.wdata = usr_wdata[arb_idx];
          s_d.init = 1'b1;
          s_d.st = cmc_pkg::ST_INIT;
        end else begin
          s_d.grant = '0;
          s_d.st = cmc_pkg::ST_IDLE;
        end
      end
      cmc_pkg::ST_INIT: begin
        s_d.cnt = '0;
        s_d.st = cmc_pkg::ST_CLEAR;
      end
      cmc_pkg::ST_CLEAR: begin
        if (s_q.cnt == CLR_LAST) begin
          s_d.cnt = '0;
          s_d.st = cmc_pkg::ST_WRITE;
          if (s_q.wr) begin
            s_d.dreg = {cmc_pkg::cmc_odd_bit(s_q.wdata), s_q.wdata};
          end else begin
            s_d.dreg = sense_data;
            s_d.rdata = sense_data[DW-1:0];
            s_d.perr = cmc_pkg::cmc_even_word(sense_data);
            s_d.ready[s_q.sel] = 1'b1;
          end
        end else begin
          s_d.cnt = s_q.cnt + CW'(1);
        end
      end
      cmc_pkg::ST_WRITE: begin
        if (s_q.cnt == WR_LAST) begin
          s_d.cnt = '0;
          s_d.rel[s_q.sel] = 1'b1;
          s_d.st = cmc_pkg::ST_REL;
        end else begin
          s_d.cnt = s_q.cnt + CW'(1);
        end
      end
      default: begin
        s_d.st = cmc_pkg::ST_IDLE;
        s_d.grant = '0;
      end
    endcase
  end

  // registers the whole state
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ********************************
  // core drives
  // ********************************
  // clear then write
  assign word_drive = (s_q.st == cmc_pkg::ST_CLEAR) ||
                      (s_q.st == cmc_pkg::ST_WRITE);
  assign drive_write = (s_q.st == cmc_pkg::ST_WRITE);
  assign bit_drive = (s_q.st == cmc_pkg::ST_CLEAR) ? '1 :
                     (s_q.st == cmc_pkg::ST_WRITE) ? s_q.dreg : '0;
  assign core_init = s_q.init;
  assign core_addr = s_q.addr;
  assign usr_grant = s_q.grant;
  assign usr_ready = s_q.ready;
  assign usr_release = s_q.rel;
  assign usr_rdata = s_q.rdata;
  assign parity_err = s_q.perr;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_grant_onehot;
    $onehot0(usr_grant);
  endproperty
  a_grant_onehot: assert property (p_grant_onehot)
    else $error("grant not one-hot");

  property p_top_priority;
    (s_q.st == cmc_pkg::ST_IDLE && usr_req[0]) |=> usr_grant[0] && core_init;
  endproperty
  a_top_priority: assert property (p_top_priority)
    else $error("channel 1 not granted first");

  property p_cycle_len;
    core_init |-> ##31 (|usr_release) ##1 !(|usr_release);
  endproperty
  a_cycle_len: assert property (p_cycle_len)
    else $error("memory cycle not 32 clocks");

  property p_ready_first;
    (|usr_ready) |-> !(|usr_release) ##15 (usr_release == $past(usr_ready, 15));
  endproperty
  a_ready_first: assert property (p_ready_first)
    else $error("release not 15 clocks after data ready");

  property p_parity;
    (|usr_ready) |-> parity_err == ~(^s_q.dreg);
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity error disagrees with word");

  property p_write_quiet;
    (core_init && s_q.wr) |-> ##16 (!(|usr_ready) && (^bit_drive));
  endproperty
  a_write_quiet: assert property (p_write_quiet)
    else $error("write gave ready or even parity");

  property p_clear_phase;
    (s_q.st == cmc_pkg::ST_CLEAR) |-> word_drive && !drive_write && (&bit_drive);
  endproperty
  a_clear_phase: assert property (p_clear_phase)
    else $error("clear phase drive wrong");

  property p_held;
    (s_q.st == cmc_pkg::ST_CLEAR || s_q.st == cmc_pkg::ST_WRITE)
      |=> $stable(core_addr) && $stable(usr_grant);
  endproperty
  a_held: assert property (p_held)
    else $error("latched request changed mid cycle");

  // run length of the clear phase, so the order check needs no long repeat
  logic [4:0] clr_run_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      clr_run_q <= 5'h0;
    end else if (word_drive && !drive_write) begin
      clr_run_q <= clr_run_q + 5'h1;
    end else begin
      clr_run_q <= 5'h0;
    end
  end

  property p_both_phases;
    core_init |=> ##15 (word_drive && drive_write && (clr_run_q == 5'hf));
  endproperty
  a_both_phases: assert property (p_both_phases)
    else $error("phase order broken");
endmodule : cmc_control
`default_nettype wire

/* design/cmc_params.svh */
// constants for the core memory cycle control
`ifndef CMC_PARAMS_SVH
`define CMC_PARAMS_SVH
`define CMC_CLK_NS 50
`define CMC_CYCLE_NS 1600
`define CMC_CLEAR_NS 750
`define CMC_DATA_W 24
`define CMC_ADDR_W 15
`define CMC_PARITY_POS 24
`define CMC_CHANNELS 4
`endif

/* design/cmc_pkg.sv */
// types and shared functions of the core memory cycle control
package cmc_pkg;
  // gray codes along the cycle path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_INIT = 3'h1,
    ST_CLEAR = 3'h3,
    ST_WRITE = 3'h2,
    ST_REL = 3'h6
  } cmc_state_t;

  // odd parity bit for a data word
  function automatic logic cmc_odd_bit(input logic [23:0] d);
    cmc_odd_bit = ~(^d);
  endfunction : cmc_odd_bit

  // true when a stored word holds an even count of ones
  function automatic logic cmc_even_word(input logic [24:0] w);
    cmc_even_word = ~(^w);
  endfunction : cmc_even_word
endpackage : cmc_pkg

/* design/cmc_arbiter.sv */
// fixed priority arbiter, index 0 highest
`timescale 1ns/10ps
`default_nettype none
module cmc_arbiter #(
  parameter int N = 4
) (
  // requests
  input wire logic [N-1:0] req,
  // winner
  output logic [N-1:0] gnt,
  output logic [$clog2(N)-1:0] idx,
  output logic any
);
  // lowest index wins, so scan downward
  always_comb begin
    gnt = '0;
    idx = '0;
    any = |req;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        gnt = '0;
        gnt[i] = 1'b1;
        idx = i[$clog2(N)-1:0];
      end
    end
  end
endmodule : cmc_arbiter
`default_nettype wire

/* bench/cmc_core_model.sv */
// behavioural core store facing the cycle control
`timescale 1ns/10ps
`default_nettype none
module cmc_core_model (
  // clock
  input wire logic sys_clk,
  // drives from the control
  input wire logic [14:0] core_addr,
  input wire logic word_drive,
  input wire logic drive_write,
  input wire logic [24:0] bit_drive,
  // fault order: flips bit 0 of sensed words
  input wire logic flip,
  // sense amplifiers
  output var logic [24:0] sense_data
);
  logic [24:0] mem [16];
  initial sense_data = 25'h0;
  always @(posedge sys_clk) begin
    if (word_drive && !drive_write) begin
      sense_data <= mem[core_addr[3:0]] ^ {24'h0, flip};
    end else begin
      sense_data <= ~sense_data; // stale sense never holds
    end
    if (word_drive && drive_write) begin
      mem[core_addr[3:0]] <= bit_drive;
    end
  end
endmodule : cmc_core_model
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench of the core memory cycle control
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] usr_req = 4'h0;
  logic [3:0] usr_write = 4'h0;
  logic [3:0][14:0] usr_addr = 60'h0;
  logic [3:0][23:0] usr_wdata = 96'h0;
  logic [3:0] usr_grant, usr_ready, usr_release;
  logic [23:0] usr_rdata;
  logic parity_err, core_init, word_drive, drive_write;
  logic flip = 1'b0;
  logic [14:0] core_addr;
  logic [24:0] bit_drive, sense_data;
  logic [31:0] rng = 32'h58346f82;
  int n_errors = 0;
  int samples_checked = 0;

  cmc_control dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .usr_req(usr_req), .usr_write(usr_write), .usr_addr(usr_addr),
    .usr_wdata(usr_wdata), .usr_grant(usr_grant), .usr_ready(usr_ready),
    .usr_release(usr_release), .usr_rdata(usr_rdata),
    .parity_err(parity_err), .core_init(core_init),
    .core_addr(core_addr), .word_drive(word_drive),
    .bit_drive(bit_drive), .drive_write(drive_write),
    .sense_data(sense_data));
  cmc_core_model core (.sys_clk(sys_clk), .core_addr(core_addr),
    .word_drive(word_drive), .drive_write(drive_write),
    .bit_drive(bit_drive), .flip(flip), .sense_data(sense_data));

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  // xorshift source
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  // stored word with odd parity on top
  function automatic logic [24:0] word(input logic [23:0] d);
    return {~(^d), d};
  endfunction : word

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  // verdict and stop
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // all channels in mask ask at once; cycles must follow priority
  task automatic run(input logic [3:0] mask, input logic wr);
    logic [3:0] g;
    logic [24:0] w;
    int k;
    usr_req = mask;
    usr_write = {4{wr}};
    // only channels that write get new words, so others keep stored data
    for (int i = 0; i < 4; i++) begin
      if (wr && mask[i]) usr_addr[i] = {13'(xs()), 2'(i)};
      if (wr && mask[i]) usr_wdata[i] = 24'(xs());
    end
    for (int i = 0; i < 4; i++) begin
      if (mask[i]) begin
        g = 4'h1 << i;
        w = word(usr_wdata[i]) ^ {24'h0, flip && !wr};
        for (k = 0; k < 40 && usr_grant === 4'h0; k++) begin
          @(posedge sys_clk);
          #1;
        end
        check(usr_grant, g);
        check({core_init, core_addr}, {1'b1, usr_addr[i]});
        usr_req[i] = 1'b0;
        for (k = 1; k < 32; k++) begin
          @(posedge sys_clk);
          #1;
          check({usr_grant, core_addr}, {g, usr_addr[i]});
          if (k < 16) check({word_drive, drive_write, bit_drive},
            {2'b10, 25'h1ffffff});
          if (k == 16) check({word_drive, drive_write, bit_drive},
            {2'b11, w});
          // writes give no ready; rdata keeps the last read word
          if (k == 16 && wr) check({usr_ready, parity_err}, 5'h0);
          // the fault order is the only way to get an even count
          if (k == 16 && !wr) check({usr_ready, parity_err, usr_rdata},
            {g, flip, w[23:0]});
          if (k == 31) check({usr_release, word_drive}, {g, 1'b0});
        end
        @(posedge sys_clk);
        #1;
        // next pending request granted on cycle 32
        check(usr_grant & ~usr_req, 4'h0);
      end
    end
    $display("test mask %h write %b done", mask, wr);
  endtask : run

  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    run(4'hf, 1'b1);
    run(4'hf, 1'b0);
    repeat (4) run(4'(xs()) | 4'h8, 1'b0);
    run(4'h6, 1'b1);
    run(4'hf, 1'b0);
    flip = 1'b1;
    run(4'h9, 1'b0);
    end_of_test();
  end

  // watchdog
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
